// ---- logic/mmd_decoder.sv ----
// Memory map decoder: code space, internal data, expanded RAM.
// Assumes the core issues at most one data access per cycle on
// ref_clk and holds the boot block count strap steady.
//
// Overview of operation
// - Flash is one code space 0x0000-0x4FFF.
// - Top 4 KB holds N 512-byte boot blocks.
// - N zero means all flash is program.
// - Boot region is aligned to flash top.
// - 256-byte RAM plus separate 768-byte expanded RAM.
// - Addresses 0x00-0x7F reachable direct and indirect.
// - Registers, bit area, general area split.
// - Upper 0x80-0xFF RAM is indirect, or direct through window banks 2-3.
// - Direct 0x80-0xFF goes to special functions.
// - Expanded RAM spans external 0x0000-0x02FF.
// - Enable bit gates external moves to the expanded RAM; the banked window ignores it.
// - External moves and banked window reach it.
// - Wide pointer past 768 bytes goes off chip.
// - Enable clear sends all external moves off.
// - Page bits plus byte pointer pick 256-byte page.
// - Window 0x40-0x7F maps 16 banks of 64.
`timescale 1ns/10ps
module mmd_decoder #(
  parameter int IRAM_DEPTH = mmd_pkg::IRAM_BYTES, // Scratchpad bytes
  parameter int XRAM_DEPTH = mmd_pkg::XRAM_BYTES // Expanded bytes
) (
  input wire logic ref_clk, // Core clock, 50 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic [3:0] boot_blocks, // Strap: boot block count
  input wire logic code_req, // Code fetch this cycle
  input wire logic [15:0] code_addr, // Code fetch address
  input wire logic acc_valid, // Data access this cycle
  input wire mmd_pkg::mmd_acc_t acc_kind, // Addressing mode
  input wire logic acc_we, // Write when high
  input wire logic [15:0] acc_addr, // Address, or {port latch, pointer}
  input wire logic [7:0] acc_wdata, // Write byte
  output logic code_flash_r, // Fetch hit flash
  output logic code_boot_r, // Fetch hit boot region
  output logic code_fault_r, // Fetch beyond flash
  output logic [7:0] code_area_r, // Flash offset high byte
  output mmd_pkg::mmd_tgt_t tgt_r, // Decoded target
  output logic [1:0] iram_area_r, // Lower RAM sub-area
  output logic sfr_req_r, // Foreign register access
  output logic [7:0] sfr_addr_r, // Its address
  output logic ext_req_r, // Off-chip access
  output logic [15:0] ext_addr_r, // Off-chip address
  output logic rd_valid_r, // Read data valid
  output logic [7:0] rd_data_r, // Read data
  output logic [7:0] sys_cfg_r, // system_configuration
  output logic [7:0] ram_page_r, // ram_page_select
  output logic [7:0] win_bank_r // window_bank_control
);

  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (IRAM_DEPTH != mmd_pkg::IRAM_BYTES) begin
      $error("mmd_decoder: IRAM_DEPTH must be 256");
    end
    if (XRAM_DEPTH < 1 || XRAM_DEPTH > mmd_pkg::XRAM_BYTES) begin
      $error("mmd_decoder: XRAM_DEPTH out of range");
    end
  end

  // ****************************************
  // Helper functions
  // ****************************************
  // First byte of the boot region for a block count
  function automatic logic [15:0] boot_base(input logic [3:0] n);
    logic [15:0] bytes;
    bytes = 16'(int'(n) * mmd_pkg::BOOT_BLOCK_BYTES);
    boot_base = mmd_pkg::FLASH_END - bytes;
  endfunction : boot_base

  // Keep implemented bits, reserved bits read zero
  function automatic logic [7:0] masked(input logic [7:0] v,
                                        input logic [7:0] m);
    masked = v & m;
  endfunction : masked

  // ****************************************
  // Strap synchroniser
  // ****************************************
  logic [3:0] blk_meta_r; // First stage, read only by second
  logic [3:0] blk_sync_r; // Second stage
  logic [3:0] blk_meta_nxt;
  logic [3:0] blk_sync_nxt;

  // Strap is a pin, so two flops before use
  always_comb begin
    blk_meta_nxt = boot_blocks;
    blk_sync_nxt = blk_meta_r;
  end

  always_ff @(posedge ref_clk) begin
    blk_meta_r <= blk_meta_nxt;
    blk_sync_r <= blk_sync_nxt;
  end

  // ****************************************
  // Code space decode
  // ****************************************
  logic [3:0] blk_cnt; // Saturated block count
  logic [15:0] boot_first; // Lowest boot address
  logic code_flash_nxt;
  logic code_boot_nxt;
  logic code_fault_nxt;
  logic [7:0] code_area_nxt;

  // Count only read, never written here
  always_comb begin
    blk_cnt = (blk_sync_r > mmd_pkg::BOOT_BLOCKS_MAX) ?
              mmd_pkg::BOOT_BLOCKS_MAX : blk_sync_r;
    boot_first = boot_base(blk_cnt); // Top aligned
    code_flash_nxt = 1'b0;
    code_boot_nxt = 1'b0;
    code_fault_nxt = 1'b0;
    code_area_nxt = 8'h00;
    if (code_req) begin
      // One contiguous flash range
      if (code_addr <= mmd_pkg::FLASH_LAST) begin
        code_flash_nxt = 1'b1;
        code_area_nxt = code_addr[15:8];
        // Zero blocks leaves no boot region
        code_boot_nxt = (blk_cnt != 4'h0) && (code_addr >= boot_first);
      end else begin
        code_fault_nxt = 1'b1; // Nothing above flash
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      code_flash_r <= 1'b0;
      code_boot_r <= 1'b0;
      code_fault_r <= 1'b0;
      code_area_r <= 8'h00;
    end else begin
      code_flash_r <= code_flash_nxt;
      code_boot_r <= code_boot_nxt;
      code_fault_r <= code_fault_nxt;
      code_area_r <= code_area_nxt;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] sys_cfg_nxt;
  logic [7:0] ram_page_nxt;
  logic [7:0] win_bank_nxt;
  logic reg_wr; // Direct write into special space
  logic xram_en; // expanded_ram_enable
  logic win_en; // window_banking_enable
  logic [3:0] win_bank; // Selected 64-byte bank
  logic [1:0] ram_page; // Byte-pointer page

  assign xram_en = sys_cfg_r[mmd_pkg::BIT_XRAM_EN];
  assign win_en = win_bank_r[mmd_pkg::BIT_WIN_BANK_EN];
  assign win_bank = win_bank_r[mmd_pkg::BIT_WIN_BANK_HIGH:
                               mmd_pkg::BIT_WIN_BANK_LOW];
  assign ram_page = ram_page_r[mmd_pkg::BIT_RAM_PAGE_HIGH:
                               mmd_pkg::BIT_RAM_PAGE_LOW];
  assign reg_wr = acc_valid && acc_we &&
                  (acc_kind == mmd_pkg::ACC_DIRECT);

  // Software writes land only through direct addressing
  always_comb begin
    sys_cfg_nxt = sys_cfg_r;
    ram_page_nxt = ram_page_r;
    win_bank_nxt = win_bank_r;
    if (reg_wr) begin
      case (acc_addr[7:0])
        mmd_pkg::ADDR_SYS_CFG: begin
          sys_cfg_nxt = masked(acc_wdata, mmd_pkg::MASK_SYS_CFG);
        end
        mmd_pkg::ADDR_RAM_PAGE: begin
          ram_page_nxt = masked(acc_wdata, mmd_pkg::MASK_RAM_PAGE);
        end
        mmd_pkg::ADDR_WIN_BANK: begin
          win_bank_nxt = masked(acc_wdata, mmd_pkg::MASK_WIN_BANK);
        end
        default: begin
          sys_cfg_nxt = sys_cfg_r; // Not ours
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sys_cfg_r <= mmd_pkg::RST_SYS_CFG;
      ram_page_r <= mmd_pkg::RST_RAM_PAGE;
      win_bank_r <= mmd_pkg::RST_WIN_BANK;
    end else begin
      sys_cfg_r <= sys_cfg_nxt;
      ram_page_r <= ram_page_nxt;
      win_bank_r <= win_bank_nxt;
    end
  end

  // ****************************************
  // Data access decode
  // ****************************************
  mmd_pkg::mmd_tgt_t tgt_nxt;
  logic [1:0] iram_area_nxt;
  logic sfr_req_nxt;
  logic [7:0] sfr_addr_nxt;
  logic ext_req_nxt;
  logic [15:0] ext_addr_nxt;
  logic iram_en; // Scratchpad strobe
  logic [7:0] iram_addr;
  logic xram_sel; // Expanded RAM strobe
  logic [9:0] xram_addr;
  logic [9:0] win_addr; // Address in the 1 KB banked space
  logic [7:0] local_rd; // Our register read value
  logic [7:0] local_rd_r; // Held for the read stage

  // Route each access to exactly one target
  always_comb begin
    tgt_nxt = mmd_pkg::TGT_NONE;
    iram_area_nxt = 2'h0;
    sfr_req_nxt = 1'b0;
    sfr_addr_nxt = 8'h00;
    ext_req_nxt = 1'b0;
    ext_addr_nxt = 16'h0000;
    iram_en = 1'b0;
    iram_addr = acc_addr[7:0];
    xram_sel = 1'b0;
    xram_addr = 10'h000;
    win_addr = {win_bank, acc_addr[5:0]};
    local_rd = 8'h00;
    if (acc_valid) begin
      case (acc_kind)
        mmd_pkg::ACC_DIRECT: begin
          if (acc_addr[7:0] >= mmd_pkg::UPPER_FIRST) begin
            // Direct upper half is register space
            case (acc_addr[7:0])
              mmd_pkg::ADDR_SYS_CFG: begin
                tgt_nxt = mmd_pkg::TGT_SFR_LOCAL;
                local_rd = sys_cfg_r;
              end
              mmd_pkg::ADDR_RAM_PAGE: begin
                tgt_nxt = mmd_pkg::TGT_SFR_LOCAL;
                local_rd = ram_page_r;
              end
              mmd_pkg::ADDR_WIN_BANK: begin
                tgt_nxt = mmd_pkg::TGT_SFR_LOCAL;
                local_rd = win_bank_r;
              end
              default: begin
                tgt_nxt = mmd_pkg::TGT_SFR_EXT; // Core's own registers
                sfr_req_nxt = 1'b1;
                sfr_addr_nxt = acc_addr[7:0];
              end
            endcase
          end else if (win_en && acc_addr[7:0] >= mmd_pkg::WINDOW_FIRST) begin
            // Banked window over the 1 KB space
            if (win_addr < 10'(mmd_pkg::IRAM_BYTES)) begin
              tgt_nxt = mmd_pkg::TGT_IRAM;
              iram_en = 1'b1;
              iram_addr = win_addr[7:0];
            end else begin
              tgt_nxt = mmd_pkg::TGT_XRAM;
              xram_sel = 1'b1;
              xram_addr = win_addr - 10'(mmd_pkg::IRAM_BYTES);
            end
          end else begin
            tgt_nxt = mmd_pkg::TGT_IRAM; // Lower half direct
            iram_en = 1'b1;
          end
        end
        mmd_pkg::ACC_INDIRECT: begin
          // Whole 256 bytes indirect; upper also through window banks 2-3
          tgt_nxt = mmd_pkg::TGT_IRAM;
          iram_en = 1'b1;
        end
        mmd_pkg::ACC_XWIDE: begin
          // On chip only when enabled and inside range
          if (xram_en && acc_addr <= mmd_pkg::XRAM_LAST) begin
            tgt_nxt = mmd_pkg::TGT_XRAM;
            xram_sel = 1'b1;
            xram_addr = acc_addr[9:0];
          end else begin
            tgt_nxt = mmd_pkg::TGT_OFFCHIP;
            ext_req_nxt = 1'b1;
            ext_addr_nxt = acc_addr;
          end
        end
        mmd_pkg::ACC_XBYTE: begin
          // Page bits join the byte pointer
          if (xram_en && ram_page != mmd_pkg::PAGE_OFFCHIP) begin
            tgt_nxt = mmd_pkg::TGT_XRAM;
            xram_sel = 1'b1;
            xram_addr = {ram_page, acc_addr[7:0]};
          end else begin
            tgt_nxt = mmd_pkg::TGT_OFFCHIP;
            ext_req_nxt = 1'b1;
            ext_addr_nxt = acc_addr; // High byte is the port latch
          end
        end
        default: begin
          tgt_nxt = mmd_pkg::TGT_NONE;
        end
      endcase
    end
    // Sub-area of lower RAM, for bit and bank logic
    if (iram_addr <= mmd_pkg::WREG_LAST) begin
      iram_area_nxt = 2'h0;
    end else if (iram_addr >= mmd_pkg::BITAREA_FIRST &&
                 iram_addr <= mmd_pkg::BITAREA_LAST) begin
      iram_area_nxt = 2'h1;
    end else if (iram_addr < mmd_pkg::UPPER_FIRST) begin
      iram_area_nxt = 2'h2;
    end else begin
      iram_area_nxt = 2'h3;
    end
  end

  // Decode results stand one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgt_r <= mmd_pkg::TGT_NONE;
      iram_area_r <= 2'h0;
      sfr_req_r <= 1'b0;
      sfr_addr_r <= 8'h00;
      ext_req_r <= 1'b0;
      ext_addr_r <= 16'h0000;
      local_rd_r <= 8'h00;
    end else begin
      tgt_r <= tgt_nxt;
      iram_area_r <= iram_area_nxt;
      sfr_req_r <= sfr_req_nxt;
      sfr_addr_r <= sfr_addr_nxt;
      ext_req_r <= ext_req_nxt;
      ext_addr_r <= ext_addr_nxt;
      local_rd_r <= local_rd;
    end
  end

  // ****************************************
  // Separate arrays, so no aliasing
  // ****************************************
  logic [7:0] iram_rd; // Scratchpad read byte
  logic [7:0] xram_rd; // Expanded read byte

  mmd_byte_ram #(.DEPTH(IRAM_DEPTH), .AW(8)) u_iram (
    .ref_clk(ref_clk),
    .en(iram_en),
    .we(acc_we),
    .addr(iram_addr),
    .wdata(acc_wdata),
    .rdata_r(iram_rd)
  );

  mmd_byte_ram #(.DEPTH(XRAM_DEPTH), .AW(10)) u_xram (
    .ref_clk(ref_clk),
    .en(xram_sel),
    .we(acc_we),
    .addr(xram_addr),
    .wdata(acc_wdata),
    .rdata_r(xram_rd)
  );

  // ****************************************
  // Read return
  // ****************************************
  logic rd_valid_nxt;
  logic [7:0] rd_data_nxt;
  logic rd_pend_r; // Read taken last cycle
  logic rd_pend_nxt;

  // Extra stage keeps the read port a plain flop
  always_comb begin
    rd_pend_nxt = acc_valid && !acc_we;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = 8'h00;
    if (rd_pend_r) begin
      case (tgt_r)
        mmd_pkg::TGT_IRAM: begin
          rd_valid_nxt = 1'b1;
          rd_data_nxt = iram_rd;
        end
        mmd_pkg::TGT_XRAM: begin
          rd_valid_nxt = 1'b1;
          rd_data_nxt = xram_rd;
        end
        mmd_pkg::TGT_SFR_LOCAL: begin
          rd_valid_nxt = 1'b1;
          rd_data_nxt = local_rd_r;
        end
        default: begin
          rd_valid_nxt = 1'b0; // Answered outside this block
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      rd_pend_r <= rd_pend_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RESET_VALUES: assert property ($past(rst) |-> sys_cfg_r == 8'h02 && win_bank_r == 8'h01)
    else $error("Register reset value wrong");
  AST_DIRECT_UPPER: assert property (acc_valid && acc_kind == mmd_pkg::ACC_DIRECT && acc_addr[7]
    |=> tgt_r inside {mmd_pkg::TGT_SFR_LOCAL, mmd_pkg::TGT_SFR_EXT})
    else $error("Direct upper access not sent to register space");
  AST_INDIRECT_RAM: assert property (acc_valid && acc_kind == mmd_pkg::ACC_INDIRECT
    |=> tgt_r == mmd_pkg::TGT_IRAM)
    else $error("Indirect access missed scratchpad");
  AST_XRAM_OFF: assert property (acc_valid && !xram_en && acc_kind[1]
    |=> ext_req_r && ext_addr_r == $past(acc_addr))
    else $error("External move stayed on chip while disabled");
  AST_WIDE_RANGE: assert property (acc_valid && xram_en && acc_kind == mmd_pkg::ACC_XWIDE
    |=> (tgt_r == mmd_pkg::TGT_XRAM) == ($past(acc_addr) < 16'h0300))
    else $error("Wide pointer range split wrong");
  AST_PAGE_THREE: assert property (acc_valid && acc_kind == mmd_pkg::ACC_XBYTE && ram_page == 2'h3
    |=> ext_req_r)
    else $error("Page three not sent off chip");
  AST_WINDOW_BANK: assert property (acc_valid && acc_kind == mmd_pkg::ACC_DIRECT && win_en
    && acc_addr[7:6] == 2'h1 && win_bank >= 4'h4 |=> tgt_r == mmd_pkg::TGT_XRAM)
    else $error("High bank not mapped to expanded RAM");
  AST_BOOT_TOP: assert property (code_req && code_addr >= 16'h4E00 && code_addr <= 16'h4FFF
    && blk_cnt != 4'h0 |=> code_boot_r)
    else $error("Top block not in boot region");
  AST_NO_BOOT: assert property (code_req && blk_cnt == 4'h0 |=> !code_boot_r)
    else $error("Boot region present with zero blocks");
  AST_READ_RETURN: assert property (acc_valid && !acc_we && acc_kind == mmd_pkg::ACC_INDIRECT
    |-> ##2 rd_valid_r)
    else $error("Scratchpad read not returned in two cycles");

endmodule : mmd_decoder

// ---- logic/mmd_pkg.sv ----
// Constants shared by the memory map decoder and its test bench.
// Assumes a single core clock and an 8-bit special function space.
package mmd_pkg;

  // ****************************************
  // Program flash map
  // ****************************************
  localparam logic [15:0] FLASH_BASE = 16'h0000; // First code byte
  localparam logic [15:0] FLASH_LAST = 16'h4FFF; // Last code byte
  localparam logic [15:0] FLASH_END = 16'h5000; // One past the top
  localparam int BOOT_BLOCK_BYTES = 512; // Boot block granule
  localparam logic [3:0] BOOT_BLOCKS_MAX = 4'h8; // Largest block count

  // ****************************************
  // Internal data space
  // ****************************************
  localparam logic [7:0] WREG_LAST = 8'h1F; // Working registers end
  localparam logic [7:0] BITAREA_FIRST = 8'h20; // Bit area start
  localparam logic [7:0] BITAREA_LAST = 8'h2F; // Bit area end
  localparam logic [7:0] UPPER_FIRST = 8'h80; // Upper half start
  localparam logic [7:0] WINDOW_FIRST = 8'h40; // Banked window start
  localparam logic [7:0] WINDOW_LAST = 8'h7F; // Banked window end
  localparam int IRAM_BYTES = 256; // Scratchpad size
  localparam int XRAM_BYTES = 768; // Expanded RAM size
  localparam logic [15:0] XRAM_LAST = 16'h02FF; // Expanded RAM top
  localparam logic [1:0] PAGE_OFFCHIP = 2'h3; // Page code sent off chip

  // ****************************************
  // Registers in special function space
  // ****************************************
  localparam logic [7:0] ADDR_RAM_PAGE = 8'h85; // ram_page_select
  localparam logic [7:0] ADDR_WIN_BANK = 8'h86; // window_bank_control
  localparam logic [7:0] ADDR_SYS_CFG = 8'hBF; // system_configuration
  localparam logic [7:0] RST_RAM_PAGE = 8'h00; // Reset values
  localparam logic [7:0] RST_WIN_BANK = 8'h01;
  localparam logic [7:0] RST_SYS_CFG = 8'h02;
  localparam logic [7:0] MASK_RAM_PAGE = 8'h03; // Implemented bits
  localparam logic [7:0] MASK_WIN_BANK = 8'h8F;
  localparam logic [7:0] MASK_SYS_CFG = 8'h97;
  localparam int BIT_RAM_PAGE_LOW = 0; // ram_page_bit_low
  localparam int BIT_RAM_PAGE_HIGH = 1; // ram_page_bit_high
  localparam int BIT_WIN_BANK_LOW = 0; // window_bank_bit0
  localparam int BIT_WIN_BANK_HIGH = 3; // window_bank_bit3
  localparam int BIT_WIN_BANK_EN = 7; // window_banking_enable
  localparam int BIT_ADDR_LATCH_INH = 0; // address_latch_inhibit
  localparam int BIT_XRAM_EN = 1; // expanded_ram_enable
  localparam int BIT_BOOT_SVC_EN = 2; // boot_service_enable
  localparam int BIT_PD_WAKE_EN = 4; // powerdown_wakeup_enable
  localparam int BIT_WDOG_FLAG = 7; // watchdog_reset_flag

  // ****************************************
  // Access kinds and decode targets
  // ****************************************
  typedef enum logic [1:0] {
    ACC_DIRECT = 2'h0, // Direct operand address
    ACC_INDIRECT = 2'h1, // Indirect through a register
    ACC_XWIDE = 2'h2, // External move, 16-bit pointer
    ACC_XBYTE = 2'h3 // External move, byte pointer
  } mmd_acc_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'h0, // No access
    TGT_IRAM = 3'h1, // Scratchpad RAM
    TGT_XRAM = 3'h2, // Expanded RAM
    TGT_SFR_LOCAL = 3'h3, // One of our own registers
    TGT_SFR_EXT = 3'h4, // Other special function register
    TGT_OFFCHIP = 3'h5 // Off-chip data memory
  } mmd_tgt_t;

endpackage : mmd_pkg

// ---- logic/mmd_byte_ram.sv ----
// Single-port byte RAM with registered read data.
// Assumes one access per cycle from the decoder on the same clock.
`timescale 1ns/10ps
module mmd_byte_ram #(
  parameter int DEPTH = 256, // Bytes held
  parameter int AW = 8 // Address width
) (
  input wire logic ref_clk, // Core clock
  input wire logic en, // Access this cycle
  input wire logic we, // Write when high
  input wire logic [AW-1:0] addr, // Byte address
  input wire logic [7:0] wdata, // Write byte
  output logic [7:0] rdata_r // Read byte, one cycle later
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] mem [DEPTH]; // Byte array

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin
      $error("mmd_byte_ram: DEPTH does not fit AW");
    end
  end

  // Read before write; read returns old data on a write cycle
  always_ff @(posedge ref_clk) begin
    if (en && int'(addr) < DEPTH) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata_r <= mem[addr];
    end
  end

endmodule : mmd_byte_ram

// ---- testbench/mmd_core_model.sv ----
// Core model: issues fetches and data accesses to the decoder.
// Assumes it is called at a falling edge of ref_clk.
`timescale 1ns/10ps
module mmd_core_model (
  input wire logic ref_clk, // Core clock
  output logic [3:0] boot_blocks, // Programmed strap
  output logic code_req, // Fetch valid
  output logic [15:0] code_addr, // Fetch address
  output logic acc_valid, // Access valid
  output mmd_pkg::mmd_acc_t acc_kind, // Addressing mode
  output logic acc_we, // Write when high
  output logic [15:0] acc_addr, // Address
  output logic [7:0] acc_wdata // Write byte
);
  // ****************************************
  // Idle levels at time zero
  // ****************************************
  initial begin
    {boot_blocks, code_req, acc_valid, acc_we} = 7'h08;
    {code_addr, acc_addr, acc_wdata} = 40'h5A5A_A5A5_3C;
    acc_kind = mmd_pkg::ACC_DIRECT;
  end
  // Strap is written only between runs, never mid-traffic
  task automatic set_strap(input logic [3:0] n);
    boot_blocks = n;
  endtask : set_strap
  // One fetch; released address shows no stale value
  task automatic fetch(input logic [15:0] a);
    {code_req, code_addr} = {1'b1, a};
    @(posedge ref_clk);
    @(negedge ref_clk);
    {code_req, code_addr} = {1'b0, ~a};
  endtask : fetch
  // One data access, held until the taking edge
  task automatic acc(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] d);
    {acc_valid, acc_we, acc_addr, acc_wdata} = {1'b1, w, a, d};
    acc_kind = mmd_pkg::mmd_acc_t'(k);
    @(posedge ref_clk);
    @(negedge ref_clk);
    {acc_valid, acc_addr, acc_wdata} = {1'b0, ~a, ~d};
  endtask : acc
endmodule : mmd_core_model

// ---- testbench/test_memory_map_decoder.sv ----
// Self-checking bench for the memory map decoder.
// Assumes the core model drives all requests at falling edges.
`timescale 1ns/10ps
module test_memory_map_decoder;
  logic ref_clk, rst; // Clock and reset
  logic [3:0] boot_blocks; // Strap
  logic code_req, acc_valid, acc_we; // Request strobes
  logic [15:0] code_addr, acc_addr, ext_addr_r; // Addresses
  logic [7:0] acc_wdata, code_area_r, sfr_addr_r, rd_data_r; // Bytes
  logic [7:0] sys_cfg_r, ram_page_r, win_bank_r; // Registers
  logic code_flash_r, code_boot_r, code_fault_r, sfr_req_r, ext_req_r, rd_valid_r; // Flags
  logic [1:0] iram_area_r; // Sub-area
  mmd_pkg::mmd_acc_t acc_kind; // Mode
  mmd_pkg::mmd_tgt_t tgt_r; // Target
  int err_total, check_count; // Tallies
  logic [7:0] ar_addr [6] = '{8'h1F, 8'h20, 8'h2F, 8'h30, 8'h7F, 8'h80}; // Area edges
  logic [1:0] ar_exp [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3}; // Their areas
  mmd_core_model core_u (.ref_clk, .boot_blocks, .code_req, .code_addr, .acc_valid, .acc_kind,
                         .acc_we, .acc_addr, .acc_wdata);
  mmd_decoder dut_u (.ref_clk, .rst, .boot_blocks, .code_req, .code_addr, .acc_valid, .acc_kind,
                     .acc_we, .acc_addr, .acc_wdata, .code_flash_r, .code_boot_r, .code_fault_r,
                     .code_area_r, .tgt_r, .iram_area_r, .sfr_req_r, .sfr_addr_r, .ext_req_r,
                     .ext_addr_r, .rd_valid_r, .rd_data_r, .sys_cfg_r, .ram_page_r, .win_bank_r);
  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // About 170 cycles expected; 5000 means a hang
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Fetch with expectation from the strap count
  task automatic fetch(input logic [15:0] a, input int n);
    logic fl;
    logic bt;
    fl = (a <= 16'h4FFF);
    bt = fl && (a >= 16'h5000 - n * 512);
    core_u.fetch(a);
    chk("code_hit", {code_flash_r, code_boot_r, code_fault_r}, {fl, bt, ~fl});
    chk("code_area", code_area_r, fl ? a[15:8] : 8'h00);
    @(negedge ref_clk);
  endtask : fetch
  // Kinds: 0 dir 1 ind 2 wide 3 byte; targets as the package
  task automatic op(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] d,
                    input logic [2:0] t);
    core_u.acc(k, w, a, d);
    chk("tgt", tgt_r, t);
    if (t == 3'h5) chk("ext_req", ext_req_r, 1'b1);
    if (t == 3'h5) chk("ext_addr", ext_addr_r, a);
    if (t == 3'h4) chk("sfr", {sfr_req_r, sfr_addr_r}, {1'b1, a[7:0]});
    @(negedge ref_clk);
  endtask : op
  // Read, then look at the data two edges on
  task automatic rd(input logic [1:0] k, input logic [15:0] a, input logic [2:0] t, input logic [7:0] e);
    op(k, 1'b0, a, 8'h00, t);
    chk("rd", {rd_valid_r, rd_data_r}, {1'b1, e});
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("regs", {sys_cfg_r, win_bank_r}, 16'h0201); // Reset values
    chk("page", ram_page_r, 8'h00); // Reset value
    rst = 1'b0;
    @(negedge ref_clk);
    // Every block count, boundaries on both sides
    for (int n = 0; n <= 8; n++) begin
      core_u.set_strap(n[3:0]);
      repeat (3) @(negedge ref_clk);
      fetch(16'(16'h5000 - n * 512), n);
      fetch(16'(16'h4FFF - n * 512), n);
      fetch(16'h4FFF, n);
      fetch(16'h5000, n);
    end
    foreach (ar_addr[i]) begin
      core_u.acc(2'h1, 1'b0, {8'h00, ar_addr[i]}, 8'h00);
      chk("area", iram_area_r, ar_exp[i]);
      @(negedge ref_clk);
    end
    op(2'h1, 1'b1, 16'h0090, 8'hA5, 3'h1);
    op(2'h0, 1'b1, 16'h0090, 8'h5A, 3'h4);
    rd(2'h1, 16'h0090, 3'h1, 8'hA5);
    op(2'h0, 1'b1, 16'h0010, 8'h11, 3'h1);
    rd(2'h1, 16'h0010, 3'h1, 8'h11);
    op(2'h2, 1'b1, 16'h0010, 8'h3C, 3'h2);
    rd(2'h2, 16'h0010, 3'h2, 8'h3C);
    rd(2'h0, 16'h0010, 3'h1, 8'h11);
    op(2'h2, 1'b1, 16'h02FF, 8'h5C, 3'h2);
    rd(2'h2, 16'h02FF, 3'h2, 8'h5C);
    op(2'h2, 1'b0, 16'h0300, 8'h00, 3'h5);
    op(2'h2, 1'b1, 16'h0110, 8'h77, 3'h2);
    op(2'h0, 1'b1, 16'h0085, 8'hFD, 3'h3);
    rd(2'h0, 16'h0085, 3'h3, 8'h01);
    rd(2'h3, 16'h0010, 3'h2, 8'h77);
    op(2'h0, 1'b1, 16'h0085, 8'h03, 3'h3);
    op(2'h3, 1'b0, 16'h4410, 8'h00, 3'h5);
    op(2'h0, 1'b1, 16'h0086, 8'h88, 3'h3);
    op(2'h0, 1'b1, 16'h0041, 8'h30, 3'h2);
    rd(2'h2, 16'h0101, 3'h2, 8'h30);
    op(2'h0, 1'b1, 16'h0086, 8'hF2, 3'h3);
    rd(2'h0, 16'h0086, 3'h3, 8'h82);
    rd(2'h0, 16'h0050, 3'h1, 8'hA5);
    op(2'h0, 1'b1, 16'h00BF, 8'hFF, 3'h3);
    chk("sys_cfg", sys_cfg_r, 8'h97);
    op(2'h0, 1'b1, 16'h0085, 8'h00, 3'h3);
    op(2'h0, 1'b1, 16'h00BF, 8'h00, 3'h3);
    op(2'h2, 1'b0, 16'h0010, 8'h00, 3'h5);
    op(2'h3, 1'b1, 16'h0010, 8'h00, 3'h5);
    wrap_up();
  end
endmodule : test_memory_map_decoder
